//--- src/imc_addr_match.v
// slave address comparator for 7-bit and 10-bit own addresses
// assumes the bus engine hands in a decoded address with its width flag
`timescale 1ns/1ns
`default_nettype none
module imc_addr_match (
    input wire [9:0] own_slave_address,
    input wire slave_wide_address,
    input wire [9:0] rx_addr,
    input wire rx_addr_wide,
    output reg hit
);
    always @* begin
        if (slave_wide_address) begin
            hit = rx_addr_wide && (rx_addr == own_slave_address); // [RL9]
        end else begin
            hit = !rx_addr_wide &&
                (rx_addr[6:0] == own_slave_address[6:0]); // [RL8]
        end
    end
endmodule // imc_addr_match
`default_nettype wire

//--- src/imc_map.vh
// constants for the two-wire controller mode-control block
// assumes inclusion by bare name from src/
`ifndef IMC_MAP_VH
`define IMC_MAP_VH
`define IMC_OFF_MODE 12'h000
`define IMC_OFF_ENABLE 12'h06c
`define IMC_OFF_SAR 12'h008
`define IMC_OFF_RIS 12'h034
`define IMC_OFF_MASK 12'h030
`define IMC_OFF_STATUS 12'h070
`define IMC_BIT_SLV_OFF 6
`define IMC_BIT_RESTART 5
`define IMC_BIT_MWIDE 4
`define IMC_BIT_SWIDE 3
`define IMC_BIT_CFG_HI 2
`define IMC_BIT_CFG_LO 1
`define IMC_BIT_MASTER 0
`define IMC_MODE_RESET 7'h3b
`define IMC_MODE_MASK 32'h0000007f
`define IMC_SAR_RESET 10'h055
`define IMC_CFG_VALUE 2'h1
`define IMC_RIS_TRANSMIT_ABORT 6
`define IMC_RIS_SLV_HIT 2
`define IMC_RIS_SPLIT 1
`define IMC_RIS_RESET 8'h00
`define IMC_MASK_RESET 8'hff
`endif

//--- src/imc_mode_ctrl.v
// mode-control register of the two-wire controller, with its gating logic
// assumes a bit-level engine that presents master requests and slave
// addresses as one-cycle pulses and obeys the grant/split outputs
// How it works
// RL1: mode and own-address writes are taken only while the enable is clear.
// RL2: with slave-off set the slave role is dropped and no address is acked.
// RL3: the restart-allow bit resets to one and permits repeated starts.
// RL4: with restarts forbidden the restart-dependent master ops are refused.
// RL5: a refused op sets the transmit-abort bit 6 of raw_irq_status.
// RL6: with restarts forbidden a split becomes a stop followed by a start.
// RL7: master_wide_address picks the 7 or 10-bit format sent as master.
// RL8: in 7-bit slave mode only the low 7 own-address bits are compared.
// RL9: in 10-bit slave mode all 10 own-address bits are compared.
// RL10: software writes 01 to bits 2:1 and they reset to 01.
// RL11: the master bit enables the master role independently of the slave.
// RL12: chip reset returns every register to its default.
// RL13: software uses aligned 32-bit accesses only.
// RL14: bits 31:7 of the mode word read zero and ignore writes.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "imc_map.vh"
module imc_mode_ctrl #(
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire reset,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire mst_req,
    input wire mst_dir_change,
    input wire mst_start_byte,
    input wire mst_combined,
    input wire mst_read,
    input wire mst_multi_byte,
    input wire bus_busy,
    input wire slv_addr_valid,
    input wire [9:0] slv_addr,
    input wire slv_addr_wide,
    output reg mst_grant,
    output reg mst_abort,
    output reg mst_split_stop_start,
    output reg mst_wide_out,
    output reg master_on,
    output reg slave_on,
    output reg slave_ack,
    output reg irq
);
    reg [6:0] mode_q;
    reg [6:0] mode_d;
    reg enable_q;
    reg [9:0] sar_q;
    reg [7:0] ris_q;
    reg [7:0] ris_d;
    reg [7:0] mask_q;
    reg [31:0] rdata_d;
    wire hit;
    wire forbidden;
    wire restart_ok;
    wire needs_split;
    wire wr_mode;
    wire wr_sar;
    wire [7:0] events;

    // aligned word decode; low two address bits are ignored [RL13]
    function is_reg;
        input [ADDR_W-1:0] a;
        input [11:0] off;
        begin
            is_reg = (a[11:2] == off[11:2]);
        end
    endfunction

    assign restart_ok = mode_q[`IMC_BIT_RESTART]; // [RL3]
    // 10-bit read needs a restart only when master sends 10-bit format
    assign forbidden = !restart_ok && (mst_start_byte || mst_combined ||
        mst_multi_byte ||
        (mst_read && mode_q[`IMC_BIT_MWIDE])); // [RL4]
    // a direction change is legal as separate transfers, not refused
    assign needs_split = !restart_ok && mst_dir_change; // [RL6]
    // config may only change while the controller is disabled
    assign wr_mode = reg_wr && !enable_q &&
        is_reg(reg_addr, `IMC_OFF_MODE); // [RL1]
    assign wr_sar = reg_wr && !enable_q && is_reg(reg_addr, `IMC_OFF_SAR);

    imc_addr_match u_match (
        .own_slave_address(sar_q),
        .slave_wide_address(mode_q[`IMC_BIT_SWIDE]),
        .rx_addr(slv_addr),
        .rx_addr_wide(slv_addr_wide),
        .hit(hit)
    );

    always @* begin
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata[6:0]; // [RL14]
        end
    end

    assign events = {1'b0,
        (mst_req && forbidden && mode_q[`IMC_BIT_MASTER]), // [RL5]
        3'h0,
        (slv_addr_valid && slave_on && hit),
        (mst_req && needs_split && !forbidden && mode_q[`IMC_BIT_MASTER]),
        1'b0};

    always @* begin
        ris_d = ris_q;
        if (reg_wr && is_reg(reg_addr, `IMC_OFF_RIS)) begin
            ris_d = ris_d & ~reg_wdata[7:0];
        end
        // a new event wins over a simultaneous clear
        ris_d = ris_d | events;
    end

    always @* begin
        rdata_d = 32'h00000000;
        if (is_reg(reg_addr, `IMC_OFF_MODE)) begin
            rdata_d = {25'h0000000, mode_q}; // [RL14]
        end else if (is_reg(reg_addr, `IMC_OFF_ENABLE)) begin
            rdata_d = {31'h00000000, enable_q};
        end else if (is_reg(reg_addr, `IMC_OFF_SAR)) begin
            rdata_d = {22'h000000, sar_q};
        end else if (is_reg(reg_addr, `IMC_OFF_RIS)) begin
            rdata_d = {24'h000000, ris_q};
        end else if (is_reg(reg_addr, `IMC_OFF_MASK)) begin
            rdata_d = {24'h000000, mask_q};
        end else if (is_reg(reg_addr, `IMC_OFF_STATUS)) begin
            rdata_d = {29'h00000000, bus_busy, slave_on, master_on};
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            mode_q <= `IMC_MODE_RESET; // [RL12] [RL10]
            enable_q <= 1'b0;
            sar_q <= `IMC_SAR_RESET;
            ris_q <= `IMC_RIS_RESET;
            mask_q <= `IMC_MASK_RESET;
            reg_rdata <= 32'h00000000;
            mst_grant <= 1'b0;
            mst_abort <= 1'b0;
            mst_split_stop_start <= 1'b0;
            mst_wide_out <= 1'b1;
            master_on <= 1'b0;
            slave_on <= 1'b0;
            slave_ack <= 1'b0;
            irq <= 1'b0;
        end else begin
            mode_q <= mode_d;
            ris_q <= ris_d;
            if (reg_wr && is_reg(reg_addr, `IMC_OFF_ENABLE)) begin
                enable_q <= reg_wdata[0];
            end
            if (wr_sar) begin
                sar_q <= reg_wdata[9:0];
            end
            if (reg_wr && is_reg(reg_addr, `IMC_OFF_MASK)) begin
                mask_q <= reg_wdata[7:0];
            end
            // read data only in the cycle after the strobe
            reg_rdata <= reg_rd ? rdata_d : 32'h00000000;
            master_on <= enable_q && mode_q[`IMC_BIT_MASTER]; // [RL11]
            slave_on <= enable_q && !mode_q[`IMC_BIT_SLV_OFF]; // [RL2]
            mst_wide_out <= mode_q[`IMC_BIT_MWIDE]; // [RL7]
            mst_grant <= mst_req && master_on && !forbidden;
            mst_abort <= mst_req && master_on && forbidden; // [RL4]
            mst_split_stop_start <= mst_req && master_on && !forbidden &&
                needs_split; // [RL6]
            slave_ack <= slv_addr_valid && slave_on && hit; // [RL2]
            irq <= |(ris_d & mask_q);
        end
    end
endmodule // imc_mode_ctrl
`default_nettype wire

//--- testbench/imc_far_end.sv
// far-side bus master model: presents decoded addresses to the slave
// assumes calls start right after a rising edge of clk
`timescale 1ns/1ns
`default_nettype none
module imc_far_end (
    input wire logic clk,
    output logic slv_addr_valid = 1'b0,
    output logic [9:0] slv_addr = 10'h3ff,
    output logic slv_addr_wide = 1'b0
);
    task automatic present(input logic [9:0] a, input logic w);
        {slv_addr_valid, slv_addr, slv_addr_wide} <= {1'b1, a, w};
        @(posedge clk);
        slv_addr_valid <= 1'b0;
        slv_addr <= ~a; // released lines must not keep the last address
    endtask
endmodule // imc_far_end
`default_nettype wire

//--- testbench/imc_mode_ctrl_tb.sv
// bench for the mode-control block: registers, master gating, slave match
// assumes imc_map.vh on the include path
`timescale 1ns/1ns
`default_nettype none
`include "imc_map.vh"
module imc_mode_ctrl_tb;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, mst_req = 0;
    logic bus_busy = 0;
    logic mst_dir_change = 0, mst_start_byte = 0, mst_combined = 0;
    logic mst_read = 0, mst_multi_byte = 0, slv_addr_valid, slv_addr_wide;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [9:0] slv_addr, sar, a;
    logic mst_grant, mst_abort, mst_split_stop_start, mst_wide_out, w;
    logic master_on, slave_on, slave_ack, irq, hit;
    logic [7:0] mk, r;
    logic [6:0] m;
    logic [4:0] q;
    logic [2:0] e;
    integer seed = 13802, err_total = 0, checks = 0, i;
    imc_mode_ctrl i_imc_mode_ctrl (.*);
    imc_far_end i_imc_far_end (.*);
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, x);
    endtask
    // order of q: dir change, start byte, combined, read, multi byte
    function automatic logic [2:0] want(input logic [4:0] k,
        input logic [6:0] c);
        if (!c[0]) return 3'h0;
        if (!c[5] && (k[3] | k[2] | k[0] | (k[1] & c[4]))) return 3'b010;
        return {2'b10, !c[5] & k[4]};
    endfunction
    task results;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000 err_total++;
        results;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`IMC_OFF_MODE, 32'h3b);
        rd(12'h0fc, 32'h0);
        wr(`IMC_OFF_MODE, 32'hffffffff);
        rd(`IMC_OFF_MODE, 32'h7f);
        wr(`IMC_OFF_ENABLE, 32'h1);
        wr(`IMC_OFF_MODE, 32'h0);
        rd(`IMC_OFF_MODE, 32'h7f);
        for (i = 0; i < 40; i++) begin
            {m, sar, mk, q, w} = 31'({$random(seed), $random(seed)});
            m[2:1] = 2'b01;
            if (i < 4) begin
                // fixed corners: restart off, master on, split and abort
                {m[5], m[0]} = 2'b01;
                q = {i[0], 3'h0, i[1]};
            end
            a = i[0] ? sar : 10'($random(seed));
            w = i[1] ? m[3] : w;
            wr(`IMC_OFF_ENABLE, 32'h0);
            wr(`IMC_OFF_MODE, {25'h0, m});
            wr(`IMC_OFF_SAR, {22'h0, sar});
            wr(`IMC_OFF_RIS, 32'hff);
            wr(`IMC_OFF_MASK, {24'h0, mk});
            wr(`IMC_OFF_ENABLE, 32'h1);
            bus_busy <= q[1];
            e = want(q, m);
            @(posedge clk);
            mst_req <= 1'b1;
            {mst_dir_change, mst_start_byte, mst_combined, mst_read,
                mst_multi_byte} <= q;
            @(posedge clk);
            mst_req <= 1'b0;
            #1;
            chk({mst_grant, mst_abort, mst_split_stop_start}, e);
            // slave side runs whatever the master bit says
            hit = !m[6] && (m[3] ? w && a == sar : !w && a[6:0] == sar[6:0]);
            @(posedge clk);
            i_imc_far_end.present(a, w);
            #1 chk(slave_ack, hit);
            r = {1'b0, e[1], 3'h0, hit, e[0], 1'b0};
            rd(`IMC_OFF_RIS, {24'h0, r});
            chk(irq, |(r & mk));
            rd(`IMC_OFF_STATUS, {29'h0, q[1], !m[6], m[0]});
            chk(mst_wide_out, m[4]);
            $display("test %0d done", i);
        end
        // a second reset in mid-run must restore the mode, own-address, raw-status and status defaults
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(`IMC_OFF_MODE, 32'h3b);
        rd(`IMC_OFF_SAR, 32'h55);
        rd(`IMC_OFF_RIS, 32'h0);
        rd(`IMC_OFF_STATUS, {29'h0, bus_busy, 2'b00});
        $display("test reset done");
        results;
    end
endmodule // imc_mode_ctrl_tb
`default_nettype wire

//--- testbench/imc_mode_monitor.sv
// checker for the mode-control block, on its top-level ports only
// assumes synchronous active-high reset on clk
`timescale 1ns/1ns
`default_nettype none
module imc_mode_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic mst_req,
    input wire logic mst_dir_change,
    input wire logic mst_start_byte,
    input wire logic mst_combined,
    input wire logic mst_read,
    input wire logic mst_multi_byte,
    input wire logic master_on,
    input wire logic slave_on,
    input wire logic slv_addr_valid,
    input wire logic slave_ack,
    input wire logic mst_grant,
    input wire logic mst_abort,
    input wire logic mst_split_stop_start,
    input wire logic [31:0] reg_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_bad_req;
        mst_req && master_on && (mst_start_byte || mst_combined);
    endsequence
    sequence s_off_req;
        mst_req && !master_on;
    endsequence
    a_req_answered: assert property (
        s_bad_req |=> mst_grant != mst_abort)
        else $error("restart-type request not answered");
    a_off_quiet: assert property (
        s_off_req |=> !mst_grant && !mst_abort)
        else $error("answer while master role off");
    a_abort_cause: assert property (
        mst_abort |-> $past(mst_req && master_on &&
        (mst_start_byte || mst_combined || mst_multi_byte || mst_read)))
        else $error("abort without a forbidden request");
    a_no_both: assert property (!(mst_grant && mst_abort))
        else $error("grant and abort together");
    a_split_cause: assert property (mst_split_stop_start |->
        mst_grant && $past(mst_dir_change)) else $error("stray split");
    a_ack_cause: assert property (slave_ack |->
        $past(slv_addr_valid) && $past(slave_on)) else $error("stray ack");
    a_on_after_wr: assert property ($rose(master_on) |->
        $past(reg_wr) || $past(reg_wr, 2)) else $error("master on unasked");
    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // imc_mode_monitor
bind imc_mode_ctrl imc_mode_monitor i_imc_mode_monitor (.*);
`default_nettype wire
